// ===== verilog/ims_map.svh
`ifndef IMS_MAP_SVH
`define IMS_MAP_SVH
// Register byte offsets.
`define IMS_OFF_BUFFER 8'h00
`define IMS_OFF_ADDR 8'h04
`define IMS_OFF_CTRL2 8'h08
`define IMS_OFF_STATUS 8'h0C
`define IMS_OFF_FLAGS 8'h10
// Control register 2 fields.
`define IMS_C2_START 0
`define IMS_C2_RESTART 1
`define IMS_C2_RECEIVE 3
`define IMS_C2_ACKSEQ 4
`define IMS_C2_ACKVAL 5
`define IMS_C2_ACK_RECEIVED_STATUS 6
// Status register fields.
`define IMS_ST_FULL 0
`define IMS_ST_START_SEEN 3
// Flag register fields (write one to clear).
`define IMS_FL_WRITE_COLLISION 0
`define IMS_FL_OVF 1
`define IMS_FL_PORT 2
`define IMS_FL_BCOL 3
// Reset values.
`define IMS_ADDR_RESET 7'h09
// Rate counter ticks twice per instruction cycle; an instruction cycle is 4 clocks.
`define IMS_TICK_DIV 2
`define IMS_TCY_CLKS 4
// Write-collision window of two instruction cycles, in clocks.
`define IMS_WRITE_COLLISION_TCY 2
`define IMS_WRITE_COLLISION_CLKS (`IMS_WRITE_COLLISION_TCY * `IMS_TCY_CLKS)
`endif

// ===== verilog/ims_pkg.sv
package ims_pkg;
   typedef enum logic [3:0] {
      IMS_IDLE = 4'h0,
      IMS_ST_WAIT = 4'h1,
      IMS_ST_HOLD = 4'h2,
      IMS_RS_LOW = 4'h3,
      IMS_RS_SDA = 4'h4,
      IMS_RS_RISE = 4'h5,
      IMS_RS_HIGH = 4'h6,
      IMS_RS_HOLD = 4'h7,
      IMS_BIT_LOW = 4'h8,
      IMS_BIT_RISE = 4'h9,
      IMS_BIT_HIGH = 4'hA,
      IMS_AK_LOW = 4'hB,
      IMS_AK_RISE = 4'hC,
      IMS_AK_HIGH = 4'hD
   } ims_state_type;
endpackage

// ===== verilog/ims_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for one line from outside the clock domain.
module ims_sync (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Asynchronous level in, synchronised level out.
   input wire logic async_in,
   output logic sync_out
);
   logic meta_reg;

   // The first flop feeds only the second.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_reg <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// ===== verilog/ims_rate.sv
`timescale 1ns/1ps
// Reload-and-count rate counter advanced by a tick enable.
module ims_rate #(
   parameter int WIDTH = 7
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Control.
   input wire logic tick_in,
   input wire logic load_in,
   input wire logic run_in,
   input wire logic [WIDTH-1:0] reload_in,
   // Timeout pulse on a tick at zero; the owner reads it only while running.
   output logic done_out
);
   logic [WIDTH-1:0] count_reg;
   logic zero;

   assign zero = (count_reg == '0);
   assign done_out = tick_in && zero;

   // Counts down to zero and holds there until the owner loads it again.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         count_reg <= '0;
      end else if (load_in) begin
         count_reg <= reload_in;
      end else if (run_in && tick_in && !zero) begin
         count_reg <= count_reg - 1'b1;
      end
   end
endmodule

// ===== verilog/ims_master.sv
`timescale 1ns/1ps
`include "ims_map.svh"
// Summary of operation
// - Released SCL stalls counter until seen high.
// - SCL high lasts a full period.
// - Start request with idle lines runs counter.
// - SDA low under high SCL sets start.
// - Second period ends start; request clears.
// - Start collision flags and returns idle.
// - Buffer write during events sets write collision.
// - Low control bits locked during start.
// - Restart pulls SCL low, releases SDA.
// - Restart holds high, then SDA low.
// - Start seen early, port flag after timeout.
// - Restart ignored unless port idle.
// - Restart collision on low SDA or SCL.
// - Buffer write transmits, one period per phase.
// - Eighth fall clears full, releases SDA.
// - Ninth fall samples acknowledge status.
// - After ninth clock flag, hold SCL low.
// - Write while shifting collides; early rewrite updates.
// - Receive request ignored unless idle.
// - Receive toggles SCL, stores byte, flags.
// - Read clears full; unread byte overflows.
// - Counter reloads seven bits, ticks twice per cycle.
// - Ack sequence drives value, one clock pulse.
module ims_master (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // AXI4-Lite write channels.
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // AXI4-Lite read channels.
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // Open-drain bus lines; enable high pulls the line low.
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_out,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out
);
   import ims_pkg::*;

   ims_state_type state_reg, state_next;
   logic scl_s, sda_s;
   logic [1:0] div_reg;
   logic tick, done, load, run;
   logic [6:0] addr_reg;
   logic [7:0] buf_reg, shift_reg;
   logic [3:0] bit_reg;
   logic rx_reg;
   logic start_rq_reg, restart_rq_reg, recv_rq_reg, ackseq_reg, ackval_reg, ack_received_status_reg;
   logic full_reg, sseen_reg, write_collision_reg, ovf_reg, pirq_reg, bcol_reg;
   logic scl_low_reg, sda_low_reg;
   logic [3:0] wwin_reg;
   logic aw_hold_reg, w_hold_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_go, rd_go, lane0;
   logic wr_buf, wr_addr, wr_c2, wr_flags, rd_buf;
   logic idle, in_start, busy_shift;
   logic set_write_collision, set_bcol, set_pirq, set_sseen, set_ovf, set_full, clr_full;
   logic clr_start, clr_restart, clr_recv, clr_ack, ack_sample, rx_store;
   logic [31:0] rd_mux;

   // Pin synchronisers.
   ims_sync u_scl_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .async_in(scl_in),
      .sync_out(scl_s)
   );
   ims_sync u_sda_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .async_in(sda_in),
      .sync_out(sda_s)
   );

   // Rate counter, ticking every second clock.
   ims_rate #(.WIDTH(7)) u_rate (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .tick_in(tick),
      .load_in(load),
      .run_in(run),
      .reload_in(addr_reg),
      .done_out(done)
   );

   assign tick = (div_reg == 2'(`IMS_TICK_DIV - 1));

   // Bus handshake decode: take a write once address and data are both held.
   assign s_axi_awready_out = !aw_hold_reg && !s_axi_bvalid_out;
   assign s_axi_wready_out = !w_hold_reg && !s_axi_bvalid_out;
   assign s_axi_arready_out = !s_axi_rvalid_out;
   assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid_out;
   assign rd_go = s_axi_arvalid_in && s_axi_arready_out;
   assign lane0 = w_strb_reg[0];
   assign wr_buf = wr_go && lane0 && (aw_addr_reg == `IMS_OFF_BUFFER);
   assign wr_addr = wr_go && lane0 && (aw_addr_reg == `IMS_OFF_ADDR);
   assign wr_c2 = wr_go && lane0 && (aw_addr_reg == `IMS_OFF_CTRL2);
   assign wr_flags = wr_go && lane0 && (aw_addr_reg == `IMS_OFF_FLAGS);
   assign rd_buf = rd_go && (s_axi_araddr_in == `IMS_OFF_BUFFER);

   // Sequencer status decode.
   assign idle = (state_reg == IMS_IDLE);
   assign in_start = (state_reg == IMS_ST_WAIT) || (state_reg == IMS_ST_HOLD)
                     || (restart_rq_reg && !idle);
   assign busy_shift = (state_reg inside {IMS_BIT_LOW, IMS_BIT_RISE, IMS_BIT_HIGH})
                       && !rx_reg;

   // Register read multiplexer; unmapped addresses read zero.
   assign rd_mux =
      (s_axi_araddr_in == `IMS_OFF_BUFFER) ? {24'h000000, buf_reg} :
      (s_axi_araddr_in == `IMS_OFF_ADDR) ? {25'h0000000, addr_reg} :
      (s_axi_araddr_in == `IMS_OFF_CTRL2) ? {25'h0000000, ack_received_status_reg, ackval_reg,
         ackseq_reg, recv_rq_reg, 1'b0, restart_rq_reg, start_rq_reg} :
      (s_axi_araddr_in == `IMS_OFF_STATUS) ? {28'h0000000, sseen_reg, 2'b00, full_reg} :
      (s_axi_araddr_in == `IMS_OFF_FLAGS) ? {28'h0000000, bcol_reg, pirq_reg, ovf_reg,
         write_collision_reg} : 32'h00000000;

   // Write collision: any buffer write outside idle, including the early rewrite window.
   assign set_write_collision = wr_buf && !idle;

   // Next-state and action logic of the sequencer.
   always_comb begin
      state_next = state_reg;
      load = 1'b0;
      run = 1'b0;
      set_bcol = 1'b0;
      set_pirq = 1'b0;
      set_sseen = 1'b0;
      clr_start = 1'b0;
      clr_restart = 1'b0;
      clr_recv = 1'b0;
      clr_ack = 1'b0;
      clr_full = 1'b0;
      ack_sample = 1'b0;
      rx_store = 1'b0;
      case (state_reg)
         IMS_IDLE: begin
            if (start_rq_reg) begin
               if (scl_s && sda_s) begin
                  load = 1'b1;
                  state_next = IMS_ST_WAIT;
               end else begin
                  set_bcol = 1'b1;
                  clr_start = 1'b1;
               end
            end else if (restart_rq_reg) begin
               if (!scl_s) begin
                  load = 1'b1;
                  state_next = IMS_RS_SDA;
               end
            end else if (recv_rq_reg || (wr_buf && !full_reg) || ackseq_reg) begin
               load = 1'b1;
               state_next = ackseq_reg ? IMS_AK_LOW : IMS_BIT_LOW;
            end
         end
         IMS_ST_WAIT: begin
            run = 1'b1;
            if (!scl_s || !sda_s) begin
               set_bcol = 1'b1;
               clr_start = 1'b1;
               state_next = IMS_IDLE;
            end else if (done) begin
               load = 1'b1;
               set_sseen = 1'b1;
               state_next = IMS_ST_HOLD;
            end
         end
         IMS_ST_HOLD: begin
            run = 1'b1;
            if (done) begin
               clr_start = 1'b1;
               set_pirq = 1'b1;
               state_next = IMS_IDLE;
            end
         end
         IMS_RS_SDA: begin
            run = 1'b1;
            if (done) begin
               if (sda_s) begin
                  state_next = IMS_RS_RISE;
               end else begin
                  set_bcol = 1'b1;
                  clr_restart = 1'b1;
                  state_next = IMS_IDLE;
               end
            end
         end
         IMS_RS_RISE: begin
            if (scl_s) begin
               if (!sda_s) begin
                  set_bcol = 1'b1;
                  clr_restart = 1'b1;
                  state_next = IMS_IDLE;
               end else begin
                  load = 1'b1;
                  state_next = IMS_RS_HIGH;
               end
            end
         end
         IMS_RS_HIGH: begin
            run = 1'b1;
            if (!scl_s) begin
               set_bcol = 1'b1;
               clr_restart = 1'b1;
               state_next = IMS_IDLE;
            end else if (done) begin
               load = 1'b1;
               set_sseen = 1'b1;
               state_next = IMS_RS_HOLD;
            end
         end
         IMS_RS_HOLD: begin
            run = 1'b1;
            if (done) begin
               clr_restart = 1'b1;
               set_pirq = 1'b1;
               state_next = IMS_IDLE;
            end
         end
         IMS_BIT_LOW, IMS_AK_LOW: begin
            run = 1'b1;
            if (done) begin
               state_next = (state_reg == IMS_AK_LOW) ? IMS_AK_RISE : IMS_BIT_RISE;
            end
         end
         IMS_BIT_RISE, IMS_AK_RISE: begin
            if (scl_s) begin
               load = 1'b1;
               state_next = (state_reg == IMS_AK_RISE) ? IMS_AK_HIGH : IMS_BIT_HIGH;
            end
         end
         IMS_BIT_HIGH: begin
            run = 1'b1;
            if (!rx_reg && !sda_low_reg && !sda_s && bit_reg < 4'h8) begin
               set_bcol = 1'b1; // arbitration loss on a transmitted one
               clr_full = 1'b1;
               state_next = IMS_IDLE;
            end else if (done) begin
               if (rx_reg && bit_reg == 4'h7) begin
                  rx_store = 1'b1;
                  clr_recv = 1'b1;
                  set_pirq = 1'b1;
                  state_next = IMS_IDLE;
               end else if (!rx_reg && bit_reg == 4'h8) begin
                  ack_sample = 1'b1;
                  set_pirq = 1'b1;
                  state_next = IMS_IDLE;
               end else begin
                  load = 1'b1;
                  clr_full = !rx_reg && (bit_reg == 4'h7);
                  state_next = IMS_BIT_LOW;
               end
            end
         end
         IMS_AK_HIGH: begin
            run = 1'b1;
            if (done) begin
               clr_ack = 1'b1;
               state_next = IMS_IDLE;
            end
         end
         default: begin
            state_next = IMS_IDLE;
         end
      endcase
   end

   assign set_full = (idle && wr_buf && !full_reg && !start_rq_reg && !restart_rq_reg
                     && !recv_rq_reg && !ackseq_reg) || rx_store;
   assign set_ovf = rx_store && full_reg;

   // Tick divider.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         div_reg <= 2'b00;
      end else begin
         div_reg <= tick ? 2'b00 : div_reg + 2'b01;
      end
   end

   // Sequencer state, bit counter, shifter and line drivers.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_reg <= IMS_IDLE;
         bit_reg <= 4'h0;
         rx_reg <= 1'b0;
         shift_reg <= 8'h00;
         scl_low_reg <= 1'b0;
         sda_low_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (idle && state_next == IMS_BIT_LOW) begin
            bit_reg <= 4'h0;
            rx_reg <= recv_rq_reg;
            shift_reg <= recv_rq_reg ? 8'h00 : s_axi_wdata_reg_byte(w_data_reg);
            scl_low_reg <= 1'b1;
            sda_low_reg <= !recv_rq_reg && !w_data_reg[7];
         end else if (idle && state_next == IMS_AK_LOW) begin
            scl_low_reg <= 1'b1;
            sda_low_reg <= !ackval_reg;
         end else if (idle && state_next == IMS_RS_SDA) begin
            sda_low_reg <= 1'b0;
         end else if (state_reg == IMS_IDLE && restart_rq_reg) begin
            scl_low_reg <= 1'b1;
         end else if (state_reg == IMS_ST_WAIT && done) begin
            sda_low_reg <= 1'b1;
         end else if (state_reg == IMS_ST_HOLD && done) begin
            scl_low_reg <= 1'b1;
         end else if (state_reg == IMS_RS_SDA && done) begin
            scl_low_reg <= 1'b0;
         end else if (state_reg == IMS_RS_HIGH && done) begin
            sda_low_reg <= 1'b1;
         end else if ((state_reg == IMS_BIT_LOW || state_reg == IMS_AK_LOW) && done) begin
            scl_low_reg <= 1'b0;
         end else if (state_reg == IMS_BIT_HIGH && done && state_next == IMS_BIT_LOW) begin
            scl_low_reg <= 1'b1;
            bit_reg <= bit_reg + 4'h1;
            if (rx_reg) begin
               shift_reg <= {shift_reg[6:0], sda_s};
            end else begin
               shift_reg <= {shift_reg[6:0], 1'b1};
               sda_low_reg <= (bit_reg < 4'h7) && !shift_reg[6];
            end
         end else if (state_reg == IMS_BIT_HIGH && done) begin
            scl_low_reg <= 1'b1;
            sda_low_reg <= 1'b0;
            if (rx_reg) begin
               shift_reg <= {shift_reg[6:0], sda_s};
            end
         end else if (state_reg == IMS_AK_HIGH && done) begin
            scl_low_reg <= 1'b1;
         end
         if (set_bcol) begin
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
         end
      end
   end

   // Byte select of the held write data.
   function automatic logic [7:0] s_axi_wdata_reg_byte(input logic [31:0] d);
      s_axi_wdata_reg_byte = d[7:0];
   endfunction

   // Control register 2 and address register; low bits locked during starts.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         addr_reg <= `IMS_ADDR_RESET;
         start_rq_reg <= 1'b0;
         restart_rq_reg <= 1'b0;
         recv_rq_reg <= 1'b0;
         ackseq_reg <= 1'b0;
         ackval_reg <= 1'b0;
         ack_received_status_reg <= 1'b0;
      end else begin
         if (wr_addr) begin
            addr_reg <= w_data_reg[6:0];
         end
         if (wr_c2 && !in_start) begin
            start_rq_reg <= w_data_reg[`IMS_C2_START] && idle;
            restart_rq_reg <= w_data_reg[`IMS_C2_RESTART] && idle;
            recv_rq_reg <= w_data_reg[`IMS_C2_RECEIVE] && idle;
            ackseq_reg <= w_data_reg[`IMS_C2_ACKSEQ] && idle;
         end else begin
            start_rq_reg <= start_rq_reg && !clr_start;
            restart_rq_reg <= restart_rq_reg && !clr_restart;
            recv_rq_reg <= recv_rq_reg && !clr_recv && !set_bcol;
            ackseq_reg <= ackseq_reg && !clr_ack && !set_bcol;
         end
         if (wr_c2) begin
            ackval_reg <= w_data_reg[`IMS_C2_ACKVAL];
         end
         if (ack_sample) begin
            ack_received_status_reg <= sda_s;
         end
      end
   end

   // Buffer, status and sticky flags; hardware set wins over software clear.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         buf_reg <= 8'h00;
         full_reg <= 1'b0;
         sseen_reg <= 1'b0;
         write_collision_reg <= 1'b0;
         ovf_reg <= 1'b0;
         pirq_reg <= 1'b0;
         bcol_reg <= 1'b0;
         wwin_reg <= 4'h0;
      end else begin
         wwin_reg <= (wwin_reg != 4'h0) ? wwin_reg - 4'h1 : 4'h0;
         if (set_full && wr_buf) begin
            buf_reg <= w_data_reg[7:0];
            wwin_reg <= 4'(`IMS_WRITE_COLLISION_CLKS);
         end else if (wr_buf && busy_shift && wwin_reg != 4'h0) begin
            buf_reg <= w_data_reg[7:0];
         end else if (rx_store) begin
            buf_reg <= {shift_reg[6:0], sda_s};
         end
         full_reg <= set_full || (full_reg && !clr_full && !rd_buf);
         sseen_reg <= set_sseen || (sseen_reg && !(idle && (start_rq_reg || wr_buf)));
         write_collision_reg <= set_write_collision || (write_collision_reg && !(wr_flags && w_data_reg[`IMS_FL_WRITE_COLLISION]));
         ovf_reg <= set_ovf || (ovf_reg && !(wr_flags && w_data_reg[`IMS_FL_OVF]));
         pirq_reg <= set_pirq || (pirq_reg && !(wr_flags && w_data_reg[`IMS_FL_PORT]));
         bcol_reg <= set_bcol || (bcol_reg && !(wr_flags && w_data_reg[`IMS_FL_BCOL]));
      end
   end

   // AXI4-Lite slave channel registers.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h00000000;
      end else begin
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr_in[7:2], 2'b00};
         end else if (wr_go) begin
            aw_hold_reg <= 1'b0;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_in;
            w_strb_reg <= s_axi_wstrb_in;
         end else if (wr_go) begin
            w_hold_reg <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid_out <= 1'b1;
         end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_mux;
         end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

   assign s_axi_bresp_out = 2'b00;
   assign s_axi_rresp_out = 2'b00;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe_out = scl_low_reg;
   assign sda_oe_out = sda_low_reg;
endmodule

// ===== bench/ims_master_props.sv
`timescale 1ns/1ps
// Checks line timing and register bus answers of the sequencer.
module ims_master_props (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Register bus.
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // Lines.
   input wire logic scl_in,
   input wire logic scl_oe_out,
   input wire logic sda_oe_out
);
   logic [7:0] hi_reg;
   logic [7:0] lo_reg;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   // Saturating counts of SCL released high and of SCL pulled low.
   always_ff @(posedge clk_in) begin
      hi_reg <= (rst_in || scl_oe_out || !scl_in) ? 8'h00 : hi_reg + 8'(!(&hi_reg));
      lo_reg <= (rst_in || !scl_oe_out) ? 8'h00 : lo_reg + 8'(!(&lo_reg));
   end
   // A write whose address and data move at one edge.
   sequence s_wr;
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
   endsequence
   a_high_min: assert property ($rose(scl_oe_out) |-> hi_reg >= 8'h14)
      else $error("SCL high short");
   a_low_min: assert property ($fell(scl_oe_out) |-> lo_reg >= 8'h12)
      else $error("SCL low short");
   a_start_scl: assert property ($rose(sda_oe_out) && !scl_oe_out |-> scl_in)
      else $error("SDA fell, SCL low");
   a_sda_free: assert property ($fell(sda_oe_out) |-> scl_oe_out)
      else $error("SDA freed, SCL high");
   a_wr_answer: assert property (s_wr |-> ##2 s_axi_bvalid_out)
      else $error("write answer");
   a_rd_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer");
   a_wr_done: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
      else $error("write held");
   a_rd_done: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
      else $error("read held");
endmodule

bind ims_master ims_master_props ims_master_props_inst (.*);

// ===== bench/ims_slave.sv
`timescale 1ns/1ps
// Slave model: acknowledges writes, sends a byte on reads, stretches SCL.
module ims_slave (
   // Clock and lines.
   input wire logic clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   // Behaviour.
   input wire logic rx_in,
   input wire logic nack_in,
   input wire logic [7:0] tx_in,
   input wire logic [7:0] hold_in,
   // Pulls.
   output logic scl_pull_out,
   output logic sda_pull_out
);
   logic scl_reg = 1'b1, sda_reg = 1'b1, pull_reg = 1'b0;
   int bits = 0, hold = 0;
   // Count SCL falls; a start resets the count ahead of its own fall.
   always @(posedge clk_in) begin
      scl_reg <= scl_in;
      sda_reg <= sda_in;
      if (scl_in && sda_reg && !sda_in) bits <= -1;
      else if (scl_reg && !scl_in) bits <= (bits == 8) ? 0 : bits + 1;
      hold <= (scl_reg && !scl_in) ? int'(hold_in) : (hold > 0 ? hold - 1 : 0);
      pull_reg <= (bits >= 0 && bits < 8) ? rx_in && !tx_in[3'(7 - bits)]
         : bits == 8 && !rx_in && !nack_in;
   end
   assign scl_pull_out = hold > 0;
   assign sda_pull_out = pull_reg;
endmodule

// ===== bench/ims_master_tb.sv
`timescale 1ns/1ps
// Drives registers over the bus while a slave model answers on the lines.
module ims_master_tb;
   logic clk_in = 1'b0, rst_in = 1'b1, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
   logic s_axi_bready_in = 1'b1, s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b1;
   logic rx_in = 1'b0, nack_in = 1'b0, jam = 1'b0;
   logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00, tx_in = 8'h00, hold_in = 8'h00, b;
   logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, q, seed = 32'h59DE;
   logic [3:0] s_axi_wstrb_in = 4'hF;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   logic s_axi_rvalid_out, scl_oe_out, sda_oe_out, scl_pull_out, sda_pull_out;
   logic [8:0] seen = 9'h000;
   int errors = 0, check_count = 0;
   // Open-drain lines with pull-ups.
   wire scl_in = !(scl_oe_out || scl_pull_out);
   wire sda_in = !(sda_oe_out || sda_pull_out || jam);
   ims_master ims_master_inst (.*, .scl_out(), .sda_out());
   ims_slave ims_slave_inst (.*);
   // Clock of 8 ns.
   initial begin
      forever #4 clk_in = ~clk_in;
   end
   // Bits seen on SDA at each SCL rise.
   always @(posedge scl_in) seen <= {seen[7:0], sda_in};
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string n, input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end while (s_axi_awvalid_in || s_axi_wvalid_in || !s_axi_bvalid_out);
      chk("bresp", s_axi_bresp_out, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      end while (s_axi_arvalid_in || !s_axi_rvalid_out);
      q = s_axi_rdata_out;
      chk("rresp", s_axi_rresp_out, 32'h0);
   endtask
   task automatic await(input logic [7:0] a, input int n, input logic v);
      for (int i = 0; i < 3000; i++) begin
         rd(a);
         if (q[n] === v) break;
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Hang guard.
   initial begin
      repeat (90000) @(posedge clk_in);
      errors++;
      stop_test();
   end
   // Main sequence.
   initial begin
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(8'h04);
      chk("reload", q, 32'h9);
      wr(8'h04, 32'h89);
      rd(8'h04);
      chk("reload write", q, 32'h9);
      rd(8'h14);
      chk("unmapped", q, 32'h0);
      jam <= 1'b1;
      wr(8'h08, 32'h1);
      repeat (60) @(posedge clk_in);
      rd(8'h10);
      chk("collision", q[3], 1'b1);
      rd(8'h08);
      chk("abort", q[0], 1'b0);
      jam <= 1'b0;
      wr(8'h10, 32'hF);
      wr(8'h08, 32'h1);
      wr(8'h00, 32'hA5);
      wr(8'h08, 32'h2);
      await(8'h08, 0, 1'b0);
      chk("start end", q[1:0], 2'h0);
      rd(8'h0C);
      chk("start seen", q[3], 1'b1);
      chk("buf kept", q[0], 1'b0);
      rd(8'h10);
      chk("start write_collision", q[0], 1'b1);
      wr(8'h10, 32'hF);
      wr(8'h08, 32'h2);
      await(8'h08, 1, 1'b0);
      rd(8'h10);
      chk("restart irq", q[2], 1'b1);
      wr(8'h10, 32'hF);
      for (int k = 0; k < 3; k++) begin
         b = 8'(rnd());
         nack_in <= b[0];
         hold_in <= {3'h0, b[5:1]};
         wr(8'h00, {24'h0, b});
         rd(8'h0C);
         chk("full", q[0], 1'b1);
         repeat (12) @(posedge clk_in);
         wr(8'h00, {24'h0, ~b});
         await(8'h10, 2, 1'b1);
         chk("wire", seen, {b, b[0]});
         rd(8'h08);
         chk("ack", q[6], b[0]);
         rd(8'h0C);
         chk("empty", q[0], 1'b0);
         rd(8'h10);
         chk("write_collision", q[0], 1'b1);
         wr(8'h10, 32'hF);
      end
      rx_in <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         b = 8'(rnd());
         tx_in <= b;
         wr(8'h08, 32'h8);
         await(8'h10, 2, 1'b1);
         chk("overflow", q[1], k == 2);
         rd(8'h0C);
         chk("rx full", q[0], 1'b1);
         if (k == 0) begin
            rd(8'h00);
            chk("rx byte", q[7:0], b);
            rd(8'h0C);
            chk("read", q[0], 1'b0);
         end
         wr(8'h10, 32'hF);
         wr(8'h08, 32'h10);
         await(8'h08, 4, 1'b0);
         chk("ack seq", q[4:3], 2'h0);
      end
      rx_in <= 1'b0;
      stop_test();
   end
endmodule
